// >>> inc/memmap_pkg.sv
// Constants and carrier types for the memory map decoder and remap logic.
// Assumes a 32-bit processor address bus and a single 100 MHz system clock.
package memmap_pkg;

   // ----------------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------------
   localparam logic [31:0] INT_MEM_TOP    = 32'h0040_0000;
   localparam logic [31:0] PERIPH_BASE    = 32'hFFC0_0000;
   localparam logic [31:0] ROM_BASE       = 32'h0010_0000;
   localparam logic [31:0] ROM_SIZE       = 32'h0002_0000;
   localparam logic [31:0] SRAM_BASE      = 32'h0030_0000;
   localparam logic [31:0] SRAM_SIZE      = 32'h0000_2000;
   localparam logic [31:0] VECTOR_TOP     = 32'h0000_0020;
   localparam logic [31:0] BOOT_WIN_SIZE  = 32'h0010_0000;
   localparam logic [31:0] PERIPH_WIN     = 32'h0000_4000;
   localparam logic [31:0] INTC_WIN       = 32'h0000_1000;
   localparam logic [31:0] INTC_BASE      = 32'hFFFF_F000;
   localparam logic [31:0] WORD_MASK      = 32'hFFFF_FFFC;
   localparam int          NUM_BANKS      = 8;
   localparam int          PERIPH_IDX_LSB = 14;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int          BOOT_SAMPLE_CYC = 10;
   localparam int          WAIT_W          = 3;
   localparam int          FLOAT_W         = 3;

   // ----------------------------------------------------------------------
   // Access sizes and bank page sizes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} acc_size_t;
   typedef enum logic [1:0] {PG_1M, PG_4M, PG_16M} page_size_t;
   typedef enum logic [1:0] {TGT_NONE, TGT_INTMEM, TGT_EXT, TGT_PERIPH} target_t;

   typedef struct packed {
      logic        en;        // bank enabled
      logic [11:0] base;      // base address bits 31:20
      page_size_t  page;      // page size
      logic [WAIT_W-1:0]  wait_cyc;   // wait states
      logic [FLOAT_W-1:0] float_cyc;  // data float cycles
      logic        bus16;     // 1: 16-bit data bus, 0: 8-bit
      logic        byte_wr;   // 1: two 8-bit devices (byte write mode)
      logic        early_rd;  // early read protocol
   } bank_cfg_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      acc_size_t   size;
      logic [31:0] addr;
   } cpu_req_t;

   typedef struct packed {
      logic        sel_rom;
      logic        sel_sram;
      logic        sel_ext;
      logic [2:0]  ext_bank;
      logic        sel_periph;
      logic [7:0]  periph_idx;
      logic [31:0] addr;      // address forwarded to the selected target
   } decode_t;

endpackage : memmap_pkg

// >>> rtl/memory_map_decoder_remap.sv
// Memory map decoder with boot select, remap and external bus sequencing.
// Assumes the processor holds its request stable until ready and that the
// outside party keeps boot_select_pin steady in the last cycles of reset.
//
// Overview of operation
// - Split space: internal, external, peripheral megabytes.
// - Little-endian byte lanes only, everywhere.
// - On-chip memories answer in one cycle.
// - Primary SRAM at zero after remap.
// - ROM decoded at fixed base address.
// - Boot memory at zero after reset.
// - Sample boot select last ten reset cycles.
// - Select one ROM, zero external chip select.
// - Boot select pin freed as I/O.
// - Remap bit swaps vector region memories.
// - Chip selects one-seven only after remap.
// - Only reset clears the remapped state.
// - Undefined external address raises abort.
// - Internal memory, peripherals never abort.
// - External unit serves middle address range.
// - Eight banks, each 1M, 4M or 16M.
// - Aligned byte, half and word accesses.
// - Per-bank wait, float and width.
// - Byte-select or byte-write for 16-bit banks.
// - Early read selectable per bank.
// - Peripheral accesses forced to whole words.
// - Peripheral windows 16K, interrupt unit 4K.
// - Watchdog reset keeps the boot mode.
`timescale 1ns/100ps

module memory_map_decoder_remap #(
   parameter int NUM_BANKS = memmap_pkg::NUM_BANKS
) (
   input  wire logic                  clk_sys,            // System clock, 100 MHz
   input  wire logic                  arst_n,             // Asynchronous reset, active low
   input  wire logic                  external_reset_n,   // Reset pin level, active low
   input  wire logic                  wdog_reset_n,       // Watchdog internal reset, active low
   input  wire logic                  boot_select_pin,    // Boot select strap / I/O line 24
   input  wire logic                  remap_command_bit,  // One-cycle write of one to remap control
   input  memmap_pkg::bank_cfg_t      bank_cfg [NUM_BANKS], // Per-bank configuration
   input  memmap_pkg::cpu_req_t       cpu_req,            // Processor request
   output memmap_pkg::decode_t        dec_out,            // Registered decode result
   output logic                       cpu_ready,          // Access completes this cycle
   output logic                       cpu_abort,          // Abort to processor
   output logic                       remapped,           // Remap done
   output logic                       boot_from_rom,      // Latched boot mode
   output logic                       pio_line_24_free,   // Boot select pin released to I/O
   output logic [NUM_BANKS-1:0]       chip_sel_n,         // Chip selects, active low
   output logic [1:0]                 byte_lane_n,        // Byte select / byte write strobes, active low
   output logic                       ext_early_rd,       // Early read for current access
   output logic                       ext_busy            // External cycle or float in progress
);

   // ----------------------------------------------------------------------
   // Reset combination and boot strap capture
   // ----------------------------------------------------------------------
   // Any reset restores the remap state, but only the pin reset resamples
   // the strap, so the watchdog leaves the boot mode as it was.
   logic       sys_rst_n;
   logic       strap_q;
   logic       boot_q;
   logic       in_reset_q;

   assign sys_rst_n = external_reset_n & wdog_reset_n;

   // The strap must be held over the last cycles before release; we capture
   // the level while the pin reset is low, and the value at release wins.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         strap_q <= 1'b1;
      end else if (!external_reset_n) begin
         strap_q <= boot_select_pin;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         in_reset_q <= 1'b1;
         boot_q     <= 1'b1;
      end else begin
         in_reset_q <= ~external_reset_n;
         if (in_reset_q && external_reset_n) begin
            boot_q <= strap_q;
         end
      end
   end

   assign boot_from_rom    = boot_q;
   assign pio_line_24_free = ~in_reset_q;

   // ----------------------------------------------------------------------
   // Remap state
   // ----------------------------------------------------------------------
   logic remap_q;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         remap_q <= 1'b0;
      end else if (!sys_rst_n) begin
         remap_q <= 1'b0;
      end else if (remap_command_bit) begin
         remap_q <= 1'b1;
      end
   end

   assign remapped = remap_q;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   memmap_pkg::decode_t dec_d;
   logic                abort_d;
   logic                hit_ext;
   logic [2:0]          hit_bank;
   logic [31:0]         a;

   always_comb begin
      a        = cpu_req.addr;
      dec_d    = '0;
      abort_d  = 1'b0;
      hit_ext  = 1'b0;
      hit_bank = 3'h0;
      dec_d.addr = a;
      // Banks are searched highest first, so the lowest bank wins where programs overlap.
      for (int b = NUM_BANKS - 1; b >= 0; b--) begin
         logic [11:0] msk;
         msk = 12'hFFF;
         case (bank_cfg[b].page)
            memmap_pkg::PG_1M:  msk = 12'hFFF;
            memmap_pkg::PG_4M:  msk = 12'hFFC;
            memmap_pkg::PG_16M: msk = 12'hFF0;
            default:            msk = 12'hFFF;
         endcase
         if (bank_cfg[b].en && ((a[31:20] & msk) == (bank_cfg[b].base & msk)) &&
             (b == 0 || remap_q)) begin
            hit_ext  = 1'b1;
            hit_bank = 3'(b);
         end
      end
      if (a >= memmap_pkg::PERIPH_BASE) begin
         dec_d.sel_periph = 1'b1;
         dec_d.addr       = a & memmap_pkg::WORD_MASK;
         dec_d.periph_idx = (a >= memmap_pkg::INTC_BASE) ?
                            8'hFF : 8'(a[21:memmap_pkg::PERIPH_IDX_LSB]);
      end else if (a < memmap_pkg::VECTOR_TOP || a < memmap_pkg::BOOT_WIN_SIZE) begin
         if (remap_q) begin
            dec_d.sel_sram = (a < memmap_pkg::SRAM_SIZE);
            dec_d.addr     = a + memmap_pkg::SRAM_BASE;
         end else if (boot_q) begin
            dec_d.sel_rom  = (a < memmap_pkg::ROM_SIZE);
            dec_d.addr     = a + memmap_pkg::ROM_BASE;
         end else begin
            dec_d.sel_ext  = 1'b1;
            dec_d.ext_bank = 3'h0;
         end
      end else if (a < memmap_pkg::INT_MEM_TOP) begin
         dec_d.sel_rom  = (a >= memmap_pkg::ROM_BASE) &&
                          (a < memmap_pkg::ROM_BASE + memmap_pkg::ROM_SIZE);
         dec_d.sel_sram = (a >= memmap_pkg::SRAM_BASE) &&
                          (a < memmap_pkg::SRAM_BASE + memmap_pkg::SRAM_SIZE);
      end else begin
         dec_d.sel_ext  = hit_ext;
         dec_d.ext_bank = hit_bank;
         abort_d        = ~hit_ext;
      end
   end

   // ----------------------------------------------------------------------
   // External bus sequencer
   // ----------------------------------------------------------------------
   typedef enum {ST_IDLE, ST_ACCESS, ST_FLOAT} ext_state_t;
   ext_state_t                     state_q;
   logic [memmap_pkg::WAIT_W-1:0]  cnt_q;
   logic [2:0]                     bank_q;
   logic                           ext_start;
   memmap_pkg::bank_cfg_t          cur_cfg;

   assign cur_cfg   = bank_cfg[dec_d.ext_bank];
   // A new external access waits out the previous bank's float time.
   assign ext_start = cpu_req.valid && dec_d.sel_ext && (state_q == ST_IDLE);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         cnt_q   <= '0;
         bank_q  <= 3'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (ext_start) begin
                  state_q <= ST_ACCESS;
                  cnt_q   <= cur_cfg.wait_cyc;
                  bank_q  <= dec_d.ext_bank;
               end
            end
            ST_ACCESS: begin
               if (cnt_q != '0) begin
                  cnt_q <= cnt_q - 1'b1;
               end else if (bank_cfg[bank_q].float_cyc != '0) begin
                  state_q <= ST_FLOAT;
                  cnt_q   <= bank_cfg[bank_q].float_cyc;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            ST_FLOAT: begin
               if (cnt_q == 3'h1) begin
                  state_q <= ST_IDLE;
               end
               cnt_q <= cnt_q - 1'b1;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign ext_busy = (state_q != ST_IDLE);

   // ----------------------------------------------------------------------
   // Strobes and byte lanes
   // ----------------------------------------------------------------------
   // Lane 0 is always the lowest address byte; there is no swapped mode.
   logic [NUM_BANKS-1:0] cs_d;
   logic [1:0]           lane_d;
   logic                 misaligned;

   assign misaligned = (cpu_req.size == memmap_pkg::SZ_HALF && cpu_req.addr[0]) ||
                       (cpu_req.size == memmap_pkg::SZ_WORD && cpu_req.addr[1:0] != 2'h0);

   always_comb begin
      cs_d   = '1;
      lane_d = 2'b11;
      if (state_q == ST_ACCESS) begin
         cs_d[bank_q] = 1'b0;
         if (!bank_cfg[bank_q].bus16) begin
            lane_d = 2'b10;
         end else if (cpu_req.size == memmap_pkg::SZ_BYTE) begin
            lane_d = cpu_req.addr[0] ? 2'b01 : 2'b10;
         end else begin
            lane_d = 2'b00;
         end
         // Byte-write mode only strobes lanes on writes; reads enable both parts.
         if (bank_cfg[bank_q].byte_wr && !cpu_req.write) begin
            lane_d = 2'b00;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         chip_sel_n   <= '1;
         byte_lane_n  <= 2'b11;
         ext_early_rd <= 1'b0;
      end else begin
         chip_sel_n   <= cs_d;
         byte_lane_n  <= lane_d;
         ext_early_rd <= (state_q == ST_ACCESS) && !cpu_req.write &&
                         bank_cfg[bank_q].early_rd;
      end
   end

   // ----------------------------------------------------------------------
   // Processor answer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dec_out <= '0;
      end else if (cpu_req.valid) begin
         dec_out <= dec_d;
      end
   end

   // On-chip targets and undefined-address aborts answer in the request cycle; external ones
   // answer on the last wait cycle.
   always_comb begin
      cpu_ready = 1'b0;
      cpu_abort = 1'b0;
      if (cpu_req.valid) begin
         if (dec_d.sel_ext) begin
            cpu_ready = (state_q == ST_ACCESS) && (cnt_q == '0);
            cpu_abort = cpu_ready && misaligned;
         end else begin
            cpu_ready = 1'b1;
            cpu_abort = abort_d;
         end
      end
   end

endmodule : memory_map_decoder_remap

// >>> verification/memmap_assertions.sv
// Concurrent checks on the memory map decoder's ports.
// Assumes one clock domain and arst_n as its reset.
`timescale 1ns/100ps

module memmap_assertions (
   input wire logic           clk_sys,           // System clock
   input wire logic           arst_n,            // Async reset, active low
   input wire logic           external_reset_n,  // Reset pin level
   input wire logic           wdog_reset_n,      // Watchdog reset
   input wire logic           boot_select_pin,   // Strap level
   input wire logic           remap_command_bit, // Remap write pulse
   input memmap_pkg::cpu_req_t cpu_req,          // Processor request
   input memmap_pkg::decode_t  dec_out,          // Decode result
   input wire logic           cpu_ready,         // Access done
   input wire logic           cpu_abort,         // Abort
   input wire logic           remapped,          // Remap state
   input wire logic           boot_from_rom,     // Boot mode
   input wire logic           pio_line_24_free   // Pin released
);
   // ---------------------------------------------------------------
   // Helper and properties
   // ---------------------------------------------------------------
   // Last strap level seen while the pin reset was low; no reset so it survives arst.
   logic strap_q;
   always_ff @(posedge clk_sys) begin
      if (!external_reset_n) strap_q <= boot_select_pin;
   end
   logic per_q, rom_q;
   assign per_q = cpu_req.valid && cpu_req.addr >= memmap_pkg::PERIPH_BASE;
   assign rom_q = cpu_req.valid && cpu_req.addr[31:17] == 15'h0008;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   a_rom_one_cycle: assert property (rom_q |-> cpu_ready && !cpu_abort)
      else $error("rom access not done in one cycle");
   a_rom_decode: assert property (rom_q |=> dec_out.sel_rom)
      else $error("rom base not decoded");
   a_periph_word: assert property (per_q |-> cpu_ready && !cpu_abort ##1
      dec_out.sel_periph && dec_out.addr == ($past(cpu_req.addr) & memmap_pkg::WORD_MASK))
      else $error("peripheral access not a clean word access");
   a_periph_window: assert property (per_q |=> dec_out.periph_idx ==
      ($past(cpu_req.addr) >= memmap_pkg::INTC_BASE ? 8'hFF : $past(cpu_req.addr[21:14])))
      else $error("peripheral window index wrong");
   a_remap_set: assert property (remap_command_bit && external_reset_n && wdog_reset_n |=> remapped)
      else $error("remap command ignored");
   a_remap_sticky: assert property (remapped && external_reset_n && wdog_reset_n |=> remapped)
      else $error("remap lost without reset");
   a_reset_clear: assert property (!external_reset_n || !wdog_reset_n |=> !remapped)
      else $error("reset did not clear remap");
   a_boot_latch: assert property ($rose(external_reset_n) |=> boot_from_rom == strap_q)
      else $error("boot mode not taken from strap");
   a_wdog_keeps_boot: assert property (!wdog_reset_n && external_reset_n |=> $stable(boot_from_rom))
      else $error("watchdog reset changed boot mode");
   a_pin_released: assert property (external_reset_n ##1 external_reset_n |-> pio_line_24_free)
      else $error("strap pin not released");

   c_remap: cover property (remap_command_bit ##1 remapped);
   c_abort: cover property (cpu_req.valid && cpu_abort);
   c_ext_boot: cover property ($rose(external_reset_n) ##1 !boot_from_rom);
endmodule // memmap_assertions

bind memory_map_decoder_remap memmap_assertions memmap_assertions_inst (.clk_sys(clk_sys), .arst_n(arst_n),
   .external_reset_n(external_reset_n), .wdog_reset_n(wdog_reset_n), .boot_select_pin(boot_select_pin),
   .remap_command_bit(remap_command_bit), .cpu_req(cpu_req), .dec_out(dec_out), .cpu_ready(cpu_ready),
   .cpu_abort(cpu_abort), .remapped(remapped), .boot_from_rom(boot_from_rom),
   .pio_line_24_free(pio_line_24_free));

// >>> verification/boot_strap_model.sv
// Board side of the boot strap pin, later reused as a toggling I/O line.
// Assumes external_reset_n is the pin reset level.
`timescale 1ns/100ps

module boot_strap_model (
   input wire logic clk_sys,          // System clock
   input wire logic external_reset_n, // Pin reset, active low
   input wire logic strap_level,      // Level held through reset
   output logic     boot_select_pin   // Strap / I/O line
);
   // Once free the line toggles every cycle, so any late resample is exposed.
   logic io_q;
   always_ff @(posedge clk_sys) begin
      if (!external_reset_n) io_q <= ~strap_level;
      else io_q <= ~io_q;
   end
   assign boot_select_pin = external_reset_n ? io_q : strap_level;
endmodule // boot_strap_model

// >>> verification/memory_map_decoder_remap_test.sv
// Directed bench for the memory map decoder and remap logic.
// Assumes the package memmap_pkg and a 100 MHz clock.
`timescale 1ns/100ps

module memory_map_decoder_remap_test;
   logic                  clk_sys, arst_n, external_reset_n, wdog_reset_n;
   logic                  remap_command_bit, strap_level, boot_select_pin, ab;
   memmap_pkg::bank_cfg_t bank_cfg [8];
   memmap_pkg::cpu_req_t  cpu_req;
   memmap_pkg::decode_t   dec_out;
   logic                  cpu_ready, cpu_abort, remapped, boot_from_rom, pio_line_24_free;
   logic                  ext_early_rd, ext_busy, er_seen;
   logic [31:0]           pa [2] = '{32'hFFFA_0003, 32'hFFFF_F102};
   logic [31:0]           pe [2] = '{32'hFFFA_0000, 32'hFFFF_F100};
   logic [7:0]            pi [2] = '{8'hE8, 8'hFF};
   logic [7:0]            chip_sel_n, cs_seen;
   logic [1:0]            byte_lane_n, ln_seen;
   int                    num_errors, cmp_count, n;

   memory_map_decoder_remap #(.NUM_BANKS(8)) memory_map_decoder_remap_inst (.clk_sys(clk_sys),
      .arst_n(arst_n), .external_reset_n(external_reset_n), .wdog_reset_n(wdog_reset_n),
      .boot_select_pin(boot_select_pin), .remap_command_bit(remap_command_bit), .bank_cfg(bank_cfg),
      .cpu_req(cpu_req), .dec_out(dec_out), .cpu_ready(cpu_ready), .cpu_abort(cpu_abort),
      .remapped(remapped), .boot_from_rom(boot_from_rom), .pio_line_24_free(pio_line_24_free),
      .chip_sel_n(chip_sel_n), .byte_lane_n(byte_lane_n), .ext_early_rd(ext_early_rd), .ext_busy(ext_busy));
   boot_strap_model boot_strap_model_inst (.clk_sys(clk_sys), .external_reset_n(external_reset_n),
      .strap_level(strap_level), .boot_select_pin(boot_select_pin));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk_flag(input logic got, input logic exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %b", $time, msg, got);
      end
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // Pin reset outlasts arst by 12 cycles so the strap is sampled by live logic.
   task automatic do_reset(input logic lvl);
      strap_level = lvl;
      arst_n = 1'b0;
      external_reset_n = 1'b0;
      repeat (3) @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (12) @(negedge clk_sys);
      external_reset_n = 1'b1;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic access(input logic [31:0] a, input memmap_pkg::acc_size_t sz, input logic wr);
      @(negedge clk_sys);
      cpu_req = '{1'b1, wr, sz, a};
      cs_seen = 8'hFF;
      ln_seen = 2'b11;
      er_seen = 1'b0;
      n = 0;
      #1;
      while (cpu_ready !== 1'b1 && n < 40) begin
         @(negedge clk_sys);
         #1;
         n++;
         cs_seen &= chip_sel_n;
         ln_seen &= byte_lane_n;
         er_seen |= ext_early_rd;
      end
      if (n == 40) begin
         num_errors++;
         $display("[FAIL] %0t access never completed", $time);
         stop_test();
      end
      ab = cpu_abort;
      @(negedge clk_sys);
      cpu_req.valid = 1'b0;
      cs_seen &= chip_sel_n;
      ln_seen &= byte_lane_n;
   endtask
   task automatic pulse(input logic wd);
      @(negedge clk_sys);
      if (wd) wdog_reset_n = 1'b0;
      else remap_command_bit = 1'b1;
      @(negedge clk_sys);
      wdog_reset_n = 1'b1;
      remap_command_bit = 1'b0;
      @(negedge clk_sys);
   endtask

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      num_errors = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      external_reset_n = 1'b0;
      wdog_reset_n = 1'b1;
      remap_command_bit = 1'b0;
      strap_level = 1'b1;
      cpu_req = '0;
      foreach (bank_cfg[i]) bank_cfg[i] = '0;
      bank_cfg[0] = '{1'b1, 12'h004, memmap_pkg::PG_1M, 3'h1, 3'h3, 1'b1, 1'b0, 1'b1};
      bank_cfg[1] = '{1'b1, 12'h005, memmap_pkg::PG_1M, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0};
      do_reset(1'b1);
      chk_flag(boot_from_rom, 1'b1, "boot mode");
      chk_flag(pio_line_24_free, 1'b1, "strap pin free");
      access(32'h0000_0000, memmap_pkg::SZ_WORD, 1'b0);
      chk_word(32'(n), 32'h0, "boot fetch latency");
      chk_flag(dec_out.sel_rom, 1'b1, "boot memory at zero");
      access(32'h0010_0004, memmap_pkg::SZ_WORD, 1'b0);
      chk_flag(dec_out.sel_rom, 1'b1, "rom base");
      for (int i = 0; i < 2; i++) begin
         access(pa[i], i ? memmap_pkg::SZ_HALF : memmap_pkg::SZ_BYTE, 1'b1);
         chk_flag(ab, 1'b0, "peripheral abort");
         chk_word(dec_out.addr, pe[i], "peripheral address");
         chk_word(32'(dec_out.periph_idx), 32'(pi[i]), "window index");
      end
      $display("test 1 boot and internal map done");
      access(32'h0050_0000, memmap_pkg::SZ_WORD, 1'b0);
      chk_flag(ab, 1'b1, "bank 1 before remap");
      access(32'h0200_0000, memmap_pkg::SZ_WORD, 1'b0);
      chk_flag(ab, 1'b1, "undefined external");
      access(32'h0040_0001, memmap_pkg::SZ_BYTE, 1'b0);
      chk_word(32'(n), 32'h2, "wait states");
      chk_word(32'(ln_seen), 32'h1, "upper byte lane");
      chk_word(32'(cs_seen), 32'hFE, "bank 0 select");
      chk_flag(er_seen, 1'b1, "early read on read");
      access(32'h0040_0002, memmap_pkg::SZ_HALF, 1'b1);
      chk_flag(n >= 4, 1'b1, "float time respected");
      chk_flag(er_seen, 1'b0, "no early read on write");
      chk_flag(ext_busy, 1'b1, "float keeps unit busy");
      chk_word(32'(ln_seen), 32'h0, "half word lanes");
      $display("test 2 external bus done");
      pulse(1'b0);
      chk_flag(remapped, 1'b1, "remap set");
      access(32'h0000_0000, memmap_pkg::SZ_WORD, 1'b1);
      chk_flag(dec_out.sel_sram, 1'b1, "sram at zero");
      access(32'h0050_0000, memmap_pkg::SZ_WORD, 1'b0);
      chk_flag(ab, 1'b0, "bank 1 after remap");
      chk_word(32'(cs_seen), 32'hFD, "bank 1 select");
      pulse(1'b1);
      chk_flag(remapped, 1'b0, "watchdog clears remap");
      chk_flag(boot_from_rom, 1'b1, "watchdog keeps mode");
      pulse(1'b0);
      $display("test 3 remap done");
      do_reset(1'b0);
      chk_flag(remapped, 1'b0, "pin reset clears remap");
      chk_flag(boot_from_rom, 1'b0, "external boot mode");
      access(32'h0000_0000, memmap_pkg::SZ_WORD, 1'b0);
      chk_flag(dec_out.sel_ext, 1'b1, "external at zero");
      chk_word(32'(dec_out.ext_bank), 32'h0, "boot bank");
      $display("test 4 external boot done");
      stop_test();
   end
endmodule // memory_map_decoder_remap_test
